// >>> rtl/wake_pkg.sv
package wake_pkg;

  // Suspend-mode field encodings
  localparam logic [1:0] SUSP_MODE_CLOCKED = 2'h0;
  localparam logic [1:0] SUSP_MODE_DEEPEST = 2'h2;
  localparam logic [1:0] SUSP_MODE_FULLCLK = 2'h3;
  localparam logic [1:0] SUSP_MODE_RESET   = SUSP_MODE_DEEPEST;

  // Wake-status field bit positions
  localparam int WAKE_STS_PHY_BIT = 0;
  localparam int WAKE_STS_MAC_BIT = 1;

  // Pin count
  localparam int PIN_COUNT = 12;

  // Wake-source register field positions
  localparam int SRC_PIN_LSB   = 0;
  localparam int SRC_PHY_BIT   = 12;
  localparam int SRC_MAGIC_BIT = 13;
  localparam int SRC_FRAME_BIT = 14;
  localparam int SRC_BCAST_BIT = 15;
  localparam int SRC_EXACT_BIT = 16;
  localparam int SRC_SYN_BIT   = 17;
  localparam int SRC_EERX_BIT  = 18;
  localparam int SRC_EETX_BIT  = 19;
  localparam int SRC_GOOD_BIT  = 20;
  localparam int SRC_RESUME_BIT = 21;
  localparam int SRC_WIDTH     = 22;

  // Remote wake pulse length in cycles
  localparam int RWAKE_CYCLES = 4;

  // Network wake events from the MAC and filter engine
  typedef struct packed {
    logic magic;
    logic wake_frame;
    logic bcast;
    logic exact;
    logic tcp_syn;
    logic eee_rx;
    logic eee_tx;
    logic good_frame;
  } net_events_t;

  // Wake configuration from software
  typedef struct packed {
    logic        network_wake_enable;
    logic        phy_wake_enable;
    logic        exact_address_wake_enable;
    logic        broadcast_wake_enable;
    logic        filter_wake_enable;
    logic        eee_rx_wake_enable;
    logic        store_wake_frame;
    logic        suspend_ind_enable;
  } wake_cfg_t;

  typedef enum logic [2:0] {
    ST_NORMAL, ST_CLOCKED, ST_DEEPEST, ST_FULLCLK, ST_EVENT_SIG, ST_DETACH
  } pwr_state_t;

endpackage

// >>> rtl/pin_wake_detect.sv
`timescale 1ns/1ps
`default_nettype none
// Per-pin wake detection: enabled pin at its wake polarity
module pin_wake_detect
  import wake_pkg::*;
#(
  parameter int N = PIN_COUNT
) (
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  input  wire logic [N-1:0] pin_in,
  input  wire logic [N-1:0] pin_enable_bit,
  input  wire logic [N-1:0] pin_wake_enable_bits,
  input  wire logic [N-1:0] pin_wake_polarity_bits,
  output logic      [N-1:0] pin_wake_hit
);

  logic [N-1:0] level_r;

  // Registered level per pin, compared against polarity
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pin
      always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
          level_r[g] <= 1'b0;
        end else begin
          level_r[g] <= ~(pin_in[g] ^ pin_wake_polarity_bits[g]);
        end
      end
      assign pin_wake_hit[g] = level_r[g] & pin_enable_bit[g] & pin_wake_enable_bits[g];
    end
  endgenerate

endmodule
`default_nettype wire

// >>> rtl/suspend_wake_event_logic.sv
// Behaviour
// - Clocked sleep accepts resume, network, energy-efficient, PHY, pin wakes; no good-frame.
// - Deepest sleep wakes only on host resume or enabled pin wake.
// - Full-clock sleep accepts everything including good-frame; never bus-power detect.
// - Event-signaling: frame, address, PHY, pin; detach mode: PHY or pin only.
// - Pin wake sets its per-pin interrupt status bit.
// - Enabled wake event notifies host; remote wakeup signaling in high speed.
// - Wake deasserts active-low suspend indication in the wake cycle if configured, else one cycle later in normal.
// - Remote wakeup only after host set the remote-wakeup feature.
// - Enabled pin wake returns to normal, signals remote wake, sets source bit.
// - Exact-address and broadcast wake need their enable bits.
// - MAC wake status bit 1 wakes immediately if set; clear blocked while event.
// - PHY wake status bit 0 wakes immediately if set; clear blocked while interrupt.
// - PHY interrupt with PHY wake enabled is the link-change wake source.
// - Link-change wake signals remote wake, returns normal, sets source bit.
// - Good-frame wake needs filter enable, network enable clear, full-clock sleep.
// - After good-frame wake store later frames; trigger frame only if enabled.
// - Mode field 00 clocked, 10 deepest, 11 full-clock; deepest by default.
// - Bus reset or reset pin reinitialise and return to unconfigured normal.
`timescale 1ns/1ps
`default_nettype none
module suspend_wake_event_logic
  import wake_pkg::*;
#(
  parameter int N = PIN_COUNT
) (
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  input  wire logic                  usb_bus_reset,
  input  wire logic                  deconfigure,
  input  wire logic [1:0]            suspend_mode_wr_data,
  input  wire logic                  suspend_mode_wr,
  input  wire logic                  suspend_req,
  input  wire logic                  event_signaling_mode,
  input  wire logic                  detach_mode,
  input  wire logic                  host_resume,
  input  wire logic                  bus_power_detect,
  input  wire logic                  high_speed,
  input  wire logic                  remote_wakeup_feature,
  input  wire wake_cfg_t             cfg,
  input  wire net_events_t           net_ev,
  input  wire logic                  mac_wake_event,
  input  wire logic                  phy_interrupt,
  input  wire logic [N-1:0]          pin_in,
  input  wire logic [N-1:0]          pin_enable_bit,
  input  wire logic [N-1:0]          pin_wake_enable_bits,
  input  wire logic [N-1:0]          pin_wake_polarity_bits,
  input  wire logic [1:0]            wake_status_clr,
  input  wire logic [SRC_WIDTH-1:0]  wake_source_clr,
  input  wire logic [N-1:0]          int_status_clr,
  output logic [1:0]                 suspend_mode,
  output logic [1:0]                 wake_status_field,
  output logic [SRC_WIDTH-1:0]       wake_source_reg,
  output logic [N-1:0]               interrupt_status_pins,
  output pwr_state_t                 power_state,
  output logic                       remote_wake,
  output logic                       wake_notify,
  output logic                       suspend_n,
  output logic                       store_trigger_frame,
  output logic                       store_frames
);

  logic [1:0]           suspend_mode_r;
  logic [1:0]           wake_status_r;
  logic [1:0]           wake_status_nxt;
  logic [SRC_WIDTH-1:0] src_r;
  logic [SRC_WIDTH-1:0] src_nxt;
  logic [N-1:0]         int_r;
  pwr_state_t           state_r;
  pwr_state_t           state_nxt;
  logic [2:0]           rwake_cnt_r;
  logic                 rwake_r;
  logic                 notify_r;
  logic                 suspend_n_r;
  logic                 store_trig_r;
  logic                 store_frames_r;
  logic [N-1:0]         pin_hit;

  pin_wake_detect #(.N(N)) u_pins (
    .ref_clk                (ref_clk),
    .reset_n                (reset_n),
    .pin_in                 (pin_in),
    .pin_enable_bit         (pin_enable_bit),
    .pin_wake_enable_bits   (pin_wake_enable_bits),
    .pin_wake_polarity_bits (pin_wake_polarity_bits),
    .pin_wake_hit           (pin_hit)
  );

  // Any reset source, including host bus reset
  wire rst_any = !reset_n || usb_bus_reset;

  // Network event qualification
  wire bcast_ok  = net_ev.bcast & cfg.broadcast_wake_enable;
  wire exact_ok  = net_ev.exact & cfg.exact_address_wake_enable;
  wire eerx_ok   = net_ev.eee_rx & cfg.eee_rx_wake_enable;
  wire good_ok   = net_ev.good_frame & cfg.filter_wake_enable
                   & ~cfg.network_wake_enable;
  wire mac_ev    = mac_wake_event | net_ev.magic | net_ev.wake_frame | bcast_ok
                   | exact_ok | net_ev.tcp_syn;
  wire pin_any   = |pin_hit;

  // Sticky status follows events; set wins over clear
  assign wake_status_nxt[WAKE_STS_MAC_BIT] = mac_ev | good_ok
      | (wake_status_r[WAKE_STS_MAC_BIT] & ~wake_status_clr[WAKE_STS_MAC_BIT]);
  assign wake_status_nxt[WAKE_STS_PHY_BIT] = phy_interrupt
      | (wake_status_r[WAKE_STS_PHY_BIT] & ~wake_status_clr[WAKE_STS_PHY_BIT]);

  // Wake conditions from status held while enabled
  wire mac_wake = wake_status_r[WAKE_STS_MAC_BIT] & cfg.network_wake_enable;
  wire phy_wake = wake_status_r[WAKE_STS_PHY_BIT] & cfg.phy_wake_enable;
  wire gf_wake  = good_ok;  // Good frame wakes in its own cycle
  wire ee_wake  = eerx_ok | net_ev.eee_tx;
  wire evsig_net = cfg.network_wake_enable
                   & (net_ev.magic | net_ev.wake_frame | bcast_ok | exact_ok);

  // Per-state acceptance
  logic wake_now;
  always_comb begin
    unique case (state_r)
      ST_CLOCKED:   wake_now = host_resume | mac_wake | ee_wake | phy_wake | pin_any;
      ST_DEEPEST:   wake_now = host_resume | pin_any;
      ST_FULLCLK:   wake_now = host_resume | mac_wake | gf_wake | ee_wake
                               | phy_wake | pin_any;
      ST_EVENT_SIG: wake_now = evsig_net | phy_wake | pin_any;
      ST_DETACH:    wake_now = phy_wake | pin_any;
      ST_NORMAL:    wake_now = 1'b0;
      default:      wake_now = 1'b0;
    endcase
  end

  // Source bits: record each cause the current sleep state accepts except mac_wake_event, as it arrives
  wire asleep   = (state_r != ST_NORMAL);
  wire clk_full = (state_r == ST_CLOCKED) || (state_r == ST_FULLCLK);
  wire net_on   = cfg.network_wake_enable && (clk_full || state_r == ST_EVENT_SIG);
  wire res_on   = clk_full || (state_r == ST_DEEPEST);
  wire phy_on   = asleep && (state_r != ST_DEEPEST);
  logic [SRC_WIDTH-1:0] src_set;
  always_comb begin
    src_set = '0;
    if (asleep) begin
      src_set[SRC_PIN_LSB +: N] = pin_hit;
    end
    src_set[SRC_PHY_BIT]    = phy_on & phy_wake;
    src_set[SRC_MAGIC_BIT]  = net_on & net_ev.magic;
    src_set[SRC_FRAME_BIT]  = net_on & net_ev.wake_frame;
    src_set[SRC_BCAST_BIT]  = net_on & bcast_ok;
    src_set[SRC_EXACT_BIT]  = net_on & exact_ok;
    src_set[SRC_SYN_BIT]    = net_on & clk_full & net_ev.tcp_syn;
    src_set[SRC_EERX_BIT]   = clk_full & eerx_ok;
    src_set[SRC_EETX_BIT]   = clk_full & net_ev.eee_tx;
    src_set[SRC_GOOD_BIT]   = (state_r == ST_FULLCLK) & gf_wake;
    src_set[SRC_RESUME_BIT] = res_on & host_resume;
  end
  assign src_nxt = src_set | (src_r & ~wake_source_clr);

  // Suspend entry picks the state from mode and special modes
  always_comb begin
    state_nxt = state_r;
    if (state_r == ST_NORMAL) begin
      if (suspend_req) begin
        if (detach_mode) begin
          state_nxt = ST_DETACH;
        end else if (event_signaling_mode) begin
          state_nxt = ST_EVENT_SIG;
        end else begin
          unique case (suspend_mode_r)
            SUSP_MODE_CLOCKED: state_nxt = ST_CLOCKED;
            SUSP_MODE_FULLCLK: state_nxt = ST_FULLCLK;
            default:           state_nxt = ST_DEEPEST;
          endcase
        end
      end
    end else if (wake_now) begin
      state_nxt = ST_NORMAL;
    end
  end

  // Remote wakeup permitted only with the feature set
  wire rwake_go = asleep && wake_now && !host_resume && remote_wakeup_feature;

  // State, status and mode registers
  always_ff @(posedge ref_clk) begin
    if (rst_any) begin
      state_r        <= ST_NORMAL;
      suspend_mode_r <= SUSP_MODE_RESET;
      wake_status_r  <= 2'h0;
      src_r          <= '0;
      int_r          <= '0;
    end else begin
      state_r        <= state_nxt;
      if (deconfigure) begin
        suspend_mode_r <= SUSP_MODE_RESET;
      end else if (suspend_mode_wr) begin
        suspend_mode_r <= suspend_mode_wr_data;
      end
      wake_status_r  <= wake_status_nxt;
      src_r          <= src_nxt;
      int_r          <= pin_hit | (int_r & ~int_status_clr);
    end
  end

  // Notification, suspend pin and frame store control
  always_ff @(posedge ref_clk) begin
    if (rst_any) begin
      rwake_cnt_r    <= 3'h0;
      rwake_r        <= 1'b0;
      notify_r       <= 1'b0;
      suspend_n_r    <= 1'b1;
      store_trig_r   <= 1'b0;
      store_frames_r <= 1'b0;
    end else begin
      notify_r <= asleep && wake_now;
      // Pulse register stays high for RWAKE_CYCLES edges
      if (rwake_go && high_speed) begin
        rwake_cnt_r <= 3'(RWAKE_CYCLES - 1);
        rwake_r     <= 1'b1;
      end else if (rwake_cnt_r != 3'h0) begin
        rwake_cnt_r <= rwake_cnt_r - 3'h1;
      end else begin
        rwake_r     <= 1'b0;
      end
      if (state_nxt != ST_NORMAL && state_r == ST_NORMAL) begin
        suspend_n_r <= 1'b0;
      end else if (asleep && wake_now && cfg.suspend_ind_enable) begin
        suspend_n_r <= 1'b1;
      end else if (state_r == ST_NORMAL) begin
        suspend_n_r <= 1'b1;
      end
      if (state_r == ST_FULLCLK && gf_wake) begin
        store_trig_r   <= cfg.store_wake_frame;
        store_frames_r <= 1'b1;
      end else if (state_nxt != ST_NORMAL && state_r == ST_NORMAL) begin
        store_trig_r   <= 1'b0;
        store_frames_r <= 1'b0;
      end
    end
  end

  assign suspend_mode          = suspend_mode_r;
  assign wake_status_field     = wake_status_r;
  assign wake_source_reg       = src_r;
  assign interrupt_status_pins = int_r;
  assign power_state           = state_r;
  assign remote_wake           = rwake_r;
  assign wake_notify           = notify_r;
  assign suspend_n             = suspend_n_r;
  assign store_trigger_frame   = store_trig_r;
  assign store_frames          = store_frames_r;

  // Checks
  property p_deep_ignores_net;
    @(posedge ref_clk) disable iff (rst_any)
    (state_r == ST_DEEPEST && !host_resume && !pin_any) |=> state_r == ST_DEEPEST;
  endproperty
  a_deep_ignores_net: assert property (p_deep_ignores_net) else $error("deep wake");

  property p_pin_int;
    @(posedge ref_clk) disable iff (rst_any)
    (|pin_hit) |=> ((int_r & $past(pin_hit)) == $past(pin_hit));
  endproperty
  a_pin_int: assert property (p_pin_int) else $error("pin int");

  property p_no_rwake_without_feature;
    @(posedge ref_clk) disable iff (rst_any)
    (!remote_wakeup_feature && !rwake_r) |=> !rwake_r;
  endproperty
  a_no_rwake_without_feature: assert property (p_no_rwake_without_feature)
    else $error("rwake");

  property p_mac_wake_immediate;
    @(posedge ref_clk) disable iff (rst_any)
    (state_r == ST_CLOCKED && mac_wake) |=> state_r == ST_NORMAL;
  endproperty
  a_mac_wake_immediate: assert property (p_mac_wake_immediate) else $error("mac");

  property p_phy_clear_blocked;
    @(posedge ref_clk) disable iff (rst_any)
    phy_interrupt |=> wake_status_r[WAKE_STS_PHY_BIT];
  endproperty
  a_phy_clear_blocked: assert property (p_phy_clear_blocked) else $error("phy");

  property p_detach_only_phy_pin;
    @(posedge ref_clk) disable iff (rst_any)
    (state_r == ST_DETACH && !phy_wake && !pin_any) |=> state_r == ST_DETACH;
  endproperty
  a_detach_only_phy_pin: assert property (p_detach_only_phy_pin) else $error("detach");

  property p_clocked_no_good;
    @(posedge ref_clk) disable iff (rst_any)
    (state_r == ST_CLOCKED && good_ok && !host_resume && !mac_wake && !ee_wake
     && !phy_wake && !pin_any) |=> state_r == ST_CLOCKED;
  endproperty
  a_clocked_no_good: assert property (p_clocked_no_good) else $error("good");

  property p_wake_notify;
    @(posedge ref_clk) disable iff (rst_any)
    (asleep && wake_now) |=> (notify_r && state_r == ST_NORMAL);
  endproperty
  a_wake_notify: assert property (p_wake_notify) else $error("notify");

  property p_good_store;
    @(posedge ref_clk) disable iff (rst_any)
    (state_r == ST_FULLCLK && gf_wake) |=> (store_frames_r && store_trig_r == $past(cfg.store_wake_frame));
  endproperty
  a_good_store: assert property (p_good_store) else $error("store");

  property p_bus_reset;
    @(posedge ref_clk) usb_bus_reset |=> state_r == ST_NORMAL && suspend_mode_r == SUSP_MODE_RESET;
  endproperty
  a_bus_reset: assert property (p_bus_reset) else $error("reset");

endmodule
`default_nettype wire

// >>> verif/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host controller side: speed, feature and resume signalling
module host_model (
  input  wire logic ref_clk,
  input  wire logic remote_wake,
  output var logic  host_resume,
  output var logic  remote_wakeup_feature,
  output var logic  high_speed,
  output var int    wake_count,
  output var int    wake_len
);
  int run_len;

  // Levels at rest
  initial begin
    host_resume = 1'b0;
    remote_wakeup_feature = 1'b1;
    high_speed = 1'b1;
    wake_count = 0;
    wake_len = 0;
    run_len = 0;
  end

  // Remote wake pulses: count and length
  always @(posedge ref_clk) begin
    if (remote_wake === 1'b1) begin
      if (run_len == 0) wake_count <= wake_count + 1;
      run_len <= run_len + 1;
    end else begin
      if (run_len != 0) wake_len <= run_len;
      run_len <= 0;
    end
  end

  // Feature only granted by the host
  task automatic set_feature(input logic f);
    remote_wakeup_feature = f;
  endtask

  // Resume signalling held a few cycles
  task automatic resume();
    host_resume = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    host_resume = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import wake_pkg::*;
  logic                 ref_clk = 1'b0;
  logic                 reset_n, usb_bus_reset, deconfigure, suspend_mode_wr, suspend_req;
  logic                 event_signaling_mode, detach_mode, host_resume, bus_power_detect;
  logic                 high_speed, remote_wakeup_feature, mac_wake_event, phy_interrupt;
  logic                 remote_wake, wake_notify, suspend_n, store_trigger_frame, store_frames;
  logic [1:0]           suspend_mode_wr_data, wake_status_clr, suspend_mode, wake_status_field;
  logic [11:0]          pin_in, pin_enable_bit, pin_wake_enable_bits, pin_wake_polarity_bits;
  logic [11:0]          int_status_clr, interrupt_status_pins;
  logic [SRC_WIDTH-1:0] wake_source_clr, wake_source_reg;
  wake_cfg_t            cfg;
  net_events_t          net_ev;
  pwr_state_t           power_state;
  int                   errors = 0;
  int                   compares = 0;
  int                   wake_count, wake_len, k, w0;
  logic [15:0]          lfsr = 16'h84DC;
  logic [1:0]           mv [3] = '{2'h0, 2'h2, 2'h3};
  logic [1:0]           pm [6] = '{2'h0, 2'h2, 2'h3, 2'h0, 2'h3, 2'h0};

  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;

  suspend_wake_event_logic suspend_wake_event_logic_inst (
    .ref_clk, .reset_n, .usb_bus_reset, .deconfigure, .suspend_mode_wr_data,
    .suspend_mode_wr, .suspend_req, .event_signaling_mode, .detach_mode, .host_resume,
    .bus_power_detect, .high_speed, .remote_wakeup_feature, .cfg, .net_ev,
    .mac_wake_event, .phy_interrupt, .pin_in, .pin_enable_bit, .pin_wake_enable_bits,
    .pin_wake_polarity_bits, .wake_status_clr, .wake_source_clr, .int_status_clr,
    .suspend_mode, .wake_status_field, .wake_source_reg, .interrupt_status_pins,
    .power_state, .remote_wake, .wake_notify, .suspend_n, .store_trigger_frame, .store_frames
  );

  host_model host_model_inst (
    .ref_clk, .remote_wake, .host_resume, .remote_wakeup_feature, .high_speed,
    .wake_count, .wake_len
  );

  // Pseudo-random source
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  // Sleep state expected for mode field and special modes
  function automatic pwr_state_t exp_st(input logic [1:0] m, input logic es, dt);
    if (dt) return ST_DETACH;
    if (es) return ST_EVENT_SIG;
    case (m)
      SUSP_MODE_CLOCKED: return ST_CLOCKED;
      SUSP_MODE_FULLCLK: return ST_FULLCLK;
      default: return ST_DEEPEST;
    endcase
  endfunction

  task automatic tick(input int n = 1);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic set_mode(input logic [1:0] m);
    suspend_mode_wr_data = m;
    suspend_mode_wr = 1'b1;
    tick();
    suspend_mode_wr = 1'b0;
  endtask

  // Host clears every pending status
  task automatic clear_all();
    wake_status_clr = 2'h3;
    wake_source_clr = '1;
    int_status_clr = '1;
    tick();
    {wake_status_clr, wake_source_clr, int_status_clr} = '0;
    tick();
  endtask

  task automatic sleep(input logic [1:0] m, input logic es, dt);
    set_mode(m);
    event_signaling_mode = es;
    detach_mode = dt;
    suspend_req = 1'b1;
    tick();
    suspend_req = 1'b0;
    tick();
    chk("sleep state", exp_st(m, es, dt), power_state);
    chk("suspend_n low", 1'b0, suspend_n);
  endtask

  task automatic wait_wake();
    for (int n = 0; power_state !== ST_NORMAL; n++) begin
      if (n > 20) begin
        errors++;
        $display("Error wake expected normal seen %0h", power_state);
        summarize();
      end else begin
        tick();
      end
    end
  endtask

  // One cycle of events in one sleep state, wake or no wake
  task automatic run_case(input logic [1:0] m, input logic es, dt, input logic [7:0] c, e,
                          input logic ph, w, input int b);
    clear_all();
    cfg = wake_cfg_t'(c);
    sleep(m, es, dt);
    w0 = wake_count;
    bus_power_detect = 1'b1;
    net_ev = net_events_t'(e);
    phy_interrupt = ph;
    tick();
    net_ev = '0;
    phy_interrupt = 1'b0;
    if (w) begin
      wait_wake();
      chk("notify", 1'b1, wake_notify);
      chk("source", 64'h1 << b, wake_source_reg);
      chk("suspend_n high", 1'b1, suspend_n);
      if (b == SRC_GOOD_BIT) chk("store", 2'h3, {store_frames, store_trigger_frame});
      tick(6);
      chk("rwake count", w0 + 1, wake_count);
      chk("rwake len", RWAKE_CYCLES, wake_len);
      chk("source held", 64'h1 << b, wake_source_reg);
    end else begin
      tick(10);
      chk("asleep", exp_st(m, es, dt), power_state);
      if (es || dt) begin
        usb_bus_reset = 1'b1;
        tick();
        usb_bus_reset = 1'b0;
      end else begin
        host_model_inst.resume();
      end
      wait_wake();
    end
    {bus_power_detect, event_signaling_mode, detach_mode} = '0;
  endtask

  initial begin
    reset_n = 1'b0;
    {usb_bus_reset, deconfigure, suspend_mode_wr, suspend_req} = '0;
    {event_signaling_mode, detach_mode, bus_power_detect, mac_wake_event} = '0;
    {phy_interrupt, suspend_mode_wr_data, wake_status_clr, wake_source_clr} = '0;
    {int_status_clr, pin_in, pin_enable_bit} = '0;
    {pin_wake_enable_bits, pin_wake_polarity_bits} = '0;
    cfg = wake_cfg_t'(8'h01);
    net_ev = '0;
    tick(8);
    reset_n = 1'b1;
    tick();
    chk("mode", SUSP_MODE_RESET, suspend_mode);
    chk("state", ST_NORMAL, power_state);
    chk("status", 0, {wake_status_field, wake_source_reg, interrupt_status_pins});
    foreach (mv[i]) begin
      set_mode(mv[i]);
      tick();
      chk("mode", mv[i], suspend_mode);
    end
    deconfigure = 1'b1;
    tick();
    deconfigure = 1'b0;
    tick();
    chk("mode", SUSP_MODE_DEEPEST, suspend_mode);
    $display("test reset_mode done");
    // Pin wake from every sleep state, last one without the feature
    for (int s = 0; s < 6; s++) begin
      k = rnd() % PIN_COUNT;
      pin_enable_bit = 12'(rnd()) | (12'h1 << k);
      pin_wake_enable_bits = 12'h1 << k;
      pin_wake_polarity_bits = 12'(rnd());
      pin_in = 12'(rnd());
      pin_in[k] = ~pin_wake_polarity_bits[k];
      host_model_inst.set_feature(s != 5);
      clear_all();
      sleep(pm[s], s == 3, s == 4);
      w0 = wake_count;
      pin_in[k] = pin_wake_polarity_bits[k];
      wait_wake();
      chk("pin int", 12'h1 << k, interrupt_status_pins);
      chk("pin source", 64'h1 << k, wake_source_reg);
      tick(6);
      chk("pin rwake", w0 + (s != 5), wake_count);
      pin_in[k] = ~pin_in[k];
      {event_signaling_mode, detach_mode} = '0;
    end
    host_model_inst.set_feature(1'b1);
    $display("test pin_wake done");
    run_case(2'h0, 0, 0, 8'h81, 8'h20, 0, 0, 0);
    run_case(2'h0, 0, 0, 8'h91, 8'h20, 0, 1, 15);
    run_case(2'h0, 0, 0, 8'hA1, 8'h10, 0, 1, 16);
    run_case(2'h0, 0, 0, 8'h81, 8'h80, 0, 1, 13);
    run_case(2'h0, 0, 0, 8'h81, 8'h08, 0, 1, 17);
    run_case(2'h0, 0, 0, 8'h85, 8'h04, 0, 1, 18);
    run_case(2'h0, 0, 0, 8'h81, 8'h02, 0, 1, 19);
    run_case(2'h0, 0, 0, 8'h09, 8'h01, 0, 0, 0);
    run_case(2'h0, 0, 0, 8'h41, 8'h00, 1, 1, 12);
    run_case(2'h2, 0, 0, 8'hFF, 8'hFF, 1, 0, 0);
    run_case(2'h3, 0, 0, 8'h0B, 8'h01, 0, 1, 20);
    run_case(2'h3, 0, 0, 8'h81, 8'h40, 0, 1, 14);
    run_case(2'h3, 0, 0, 8'h41, 8'h00, 1, 1, 12);
    run_case(2'h0, 1, 0, 8'h81, 8'h08, 0, 0, 0);
    run_case(2'h0, 1, 0, 8'h91, 8'h20, 0, 1, 15);
    run_case(2'h3, 0, 1, 8'h81, 8'h80, 0, 0, 0);
    run_case(2'h3, 0, 1, 8'h41, 8'h00, 1, 1, 12);
    $display("test net_wake done");
    // Status held through a blocked clear causes an immediate re-wake
    clear_all();
    cfg = wake_cfg_t'(8'hC1);
    set_mode(SUSP_MODE_CLOCKED);
    {mac_wake_event, phy_interrupt} = 2'h3;
    tick(2);
    wake_status_clr = 2'h3;
    tick();
    wake_status_clr = 2'h0;
    tick();
    chk("status held", 2'h3, wake_status_field);
    {mac_wake_event, phy_interrupt} = 2'h0;
    w0 = wake_count;
    suspend_req = 1'b1;
    tick();
    suspend_req = 1'b0;
    tick(2);
    wait_wake();
    tick(8);
    chk("stale rwake", w0 + 1, wake_count);
    clear_all();
    chk("status clear", 2'h0, wake_status_field);
    $display("test stale_status done");
    sleep(SUSP_MODE_FULLCLK, 0, 0);
    usb_bus_reset = 1'b1;
    tick();
    usb_bus_reset = 1'b0;
    tick();
    chk("bus reset", {ST_NORMAL, SUSP_MODE_RESET}, {power_state, suspend_mode});
    $display("test bus_reset done");
    summarize();
  end
endmodule
`default_nettype wire
